/* hdl/led_sink_pkg.sv */
package led_sink_pkg;

  // ==========================================================
  // geometry
  localparam int CHANNELS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // blank-low run lengths, counted in shift-clock edges
  localparam logic [1:0] MODE_PULSE_EDGES = 2'h1; // one-clock low pulse switches mode
  localparam logic [1:0] READ_LOW_EDGES = 2'h2;   // longer low window reads error status

  // ==========================================================
  // reset values
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] ERROR_RESET = 16'h0000;
  localparam logic [3:0] PIN_IDLE = 4'h8; // blank rests high on its pull-up, the rest low

  // ==========================================================
  // operating modes
  typedef enum logic
  {
    MODE_NORMAL = 1'b0,
    MODE_SPECIAL = 1'b1
  } mode_e;

endpackage

/* hdl/status_fifo.sv */
`timescale 1ns/1ps
module status_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic in_valid, // source offers a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word from source
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // sink takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // elaboration checks
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("status_fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  // ==========================================================
  // handshakes
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - (AW+1)'(1);
    end
  end

  // storage; no reset needed for the data array
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy; ready is registered so the source sees a clean flop
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

endmodule

/* hdl/led_sink_serial_control.sv */
// What this block does
// - shift serial input, output bit fifteen edges back
// - normal mode: latch follows while strobe high
// - blank high turns all sinks off
// - defined control sequence enters special mode
// - special mode strobe pulse writes configuration latch
// - read sequence delivers error status serially
// - error status loaded into shift register, shifted
// - one sticky error bit per channel
// - return to normal clears error register
// - blank low enables sinks in every mode
`timescale 1ns/1ps
module led_sink_serial_control
#(
  parameter int CHANNELS = led_sink_pkg::CHANNELS,
  parameter int FIFO_DEPTH = led_sink_pkg::FIFO_DEPTH
)
(
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic shift_clk, // shift clock pin, sampled
  input wire logic serial_in, // serial data pin
  input wire logic latch_strobe_ctl_one, // latch strobe pin
  input wire logic output_blank_ctl_two, // blank pin, high turns sinks off
  input wire logic fault_valid, // channel monitor offers a fault word
  input wire logic [CHANNELS-1:0] fault_word, // one bit per faulty channel
  output logic fault_ready, // fault buffer has room
  output logic serial_out, // serial data to next device
  output logic [CHANNELS-1:0] sink_channels, // sink enables, high sinks current
  output logic [CHANNELS-1:0] current_adjust_code, // configuration latch
  output logic special_mode // high while in special mode
);

  // ==========================================================
  // elaboration checks
  if (CHANNELS != 16)
  begin : g_bad_channels
    $error("the serial chain is sixteen stages long");
  end

  // ==========================================================
  // pin synchronisers reset to idle pin levels, so no false blank-low follows reset
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  assign pin_raw = {output_blank_ctl_two, latch_strobe_ctl_one, serial_in, shift_clk};

  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        pin_meta[i] <= led_sink_pkg::PIN_IDLE[i];
        pin_sync[i] <= led_sink_pkg::PIN_IDLE[i];
      end
      else
      begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  logic shift_clk_s;
  logic serial_in_s;
  logic strobe_s;
  logic blank_s;
  assign shift_clk_s = pin_sync[0];
  assign serial_in_s = pin_sync[1];
  assign strobe_s = pin_sync[2];
  assign blank_s = pin_sync[3];

  // edge detectors look at synchronised levels only
  logic shift_clk_d;
  logic strobe_d;
  logic shift_edge;
  logic strobe_rise;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      shift_clk_d <= 1'b0;
      strobe_d <= 1'b0;
    end
    else
    begin
      shift_clk_d <= shift_clk_s;
      strobe_d <= strobe_s;
    end
  end
  assign shift_edge = shift_clk_s & ~shift_clk_d;
  assign strobe_rise = strobe_s & ~strobe_d;

  // ==========================================================
  // blank-low run tracking on shift-clock edges
  logic [1:0] low_edges;
  logic strobe_at_low;
  logic mode_switch;
  logic read_load;
  led_sink_pkg::mode_e mode;

  assign mode_switch = shift_edge & blank_s & (low_edges == led_sink_pkg::MODE_PULSE_EDGES);
  assign read_load = shift_edge & blank_s & (low_edges >= led_sink_pkg::READ_LOW_EDGES)
                     & (mode == led_sink_pkg::MODE_SPECIAL);

  // counts saturate so a long blank never wraps into a mode pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      low_edges <= 2'h0;
      strobe_at_low <= 1'b0;
    end
    else if (shift_edge)
    begin
      if (blank_s)
      begin
        low_edges <= 2'h0;
      end
      else
      begin
        if (low_edges != 2'h3)
        begin
          low_edges <= low_edges + 2'h1;
        end
        if (low_edges == 2'h0)
        begin
          strobe_at_low <= strobe_s;
        end
      end
    end
  end

  // mode register; strobe level caught during the pulse chooses the target
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode <= led_sink_pkg::MODE_NORMAL;
    end
    else if (mode_switch)
    begin
      mode <= strobe_at_low ? led_sink_pkg::MODE_SPECIAL : led_sink_pkg::MODE_NORMAL;
    end
  end

  // ==========================================================
  // shift register: shifts each edge, or takes the error snapshot
  logic [CHANNELS-1:0] shift_reg;
  logic [CHANNELS-1:0] error_reg;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      shift_reg <= led_sink_pkg::SHIFT_RESET;
    end
    else if (read_load)
    begin
      shift_reg <= error_reg;
    end
    else if (shift_edge)
    begin
      shift_reg <= {shift_reg[CHANNELS-2:0], serial_in_s};
    end
  end
  assign serial_out = shift_reg[CHANNELS-1];

  // ==========================================================
  // output and configuration latches
  logic [CHANNELS-1:0] out_latch;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      out_latch <= led_sink_pkg::LATCH_RESET;
    end
    else if (strobe_s && mode == led_sink_pkg::MODE_NORMAL)
    begin
      out_latch <= shift_reg;
    end
  end

  // in special mode the strobe goes to the configuration latch instead
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      current_adjust_code <= led_sink_pkg::CONFIG_RESET;
    end
    else if (strobe_rise && mode == led_sink_pkg::MODE_SPECIAL)
    begin
      current_adjust_code <= shift_reg;
    end
  end

  // blank acts the same in both modes
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sink_channels <= '0;
      special_mode <= 1'b0;
    end
    else
    begin
      sink_channels <= blank_s ? '0 : out_latch;
      special_mode <= (mode == led_sink_pkg::MODE_SPECIAL);
    end
  end

  // ==========================================================
  // fault buffering; detection only counts while sinks are enabled
  logic fault_out_valid;
  logic fault_drain;
  logic fault_pop;
  logic error_clear;
  logic [CHANNELS-1:0] fault_head;

  assign fault_drain = ~blank_s;
  assign fault_pop = fault_out_valid & fault_drain;
  assign error_clear = mode_switch & ~strobe_at_low;

  status_fifo #(
    .WIDTH(CHANNELS),
    .DEPTH(FIFO_DEPTH)
  ) u_fault_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(fault_valid),
    .in_ready(fault_ready),
    .in_data(fault_word),
    .out_valid(fault_out_valid),
    .out_ready(fault_drain),
    .out_data(fault_head)
  );

  // sticky error bits; a fault arriving on the clearing edge survives it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      error_reg <= led_sink_pkg::ERROR_RESET;
    end
    else if (error_clear)
    begin
      error_reg <= fault_pop ? fault_head : '0;
    end
    else if (fault_pop)
    begin
      error_reg <= error_reg | fault_head;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_enter_special;
    mode_switch && strobe_at_low;
  endsequence

  sequence s_return_normal;
    mode_switch && !strobe_at_low;
  endsequence

  chk_shift_chain: assert property (shift_edge && !read_load |=>
    shift_reg == {$past(shift_reg[CHANNELS-2:0]), $past(serial_in_s)})
    else $error("shift register did not shift in the serial bit");

  chk_latch_follow: assert property (strobe_s && mode == led_sink_pkg::MODE_NORMAL |=>
    out_latch == $past(shift_reg))
    else $error("output latch did not follow the shift register");

  chk_latch_hold: assert property (!strobe_s |=> $stable(out_latch))
    else $error("output latch changed with strobe low");

  chk_blank_off: assert property (blank_s |=> sink_channels == '0)
    else $error("sinks active while blanked");

  chk_sink_enable: assert property (!blank_s |=> sink_channels == $past(out_latch))
    else $error("sinks do not show the latch while enabled");

  chk_enter_special: assert property (s_enter_special |=> mode == led_sink_pkg::MODE_SPECIAL ##1 special_mode)
    else $error("mode pulse with strobe high did not enter special mode");

  chk_return_normal: assert property (s_return_normal |=>
    mode == led_sink_pkg::MODE_NORMAL ##1 !special_mode)
    else $error("mode pulse with strobe low did not return to normal");

  chk_config_write: assert property (strobe_rise && mode == led_sink_pkg::MODE_SPECIAL |=>
    current_adjust_code == $past(shift_reg))
    else $error("configuration latch not written");

  chk_error_load: assert property (read_load |=>
    shift_reg == $past(error_reg) ##1 serial_out == $past(error_reg[CHANNELS-1], 2))
    else $error("error status not loaded into shift register");

  chk_error_sticky: assert property (!error_clear |=> (($past(error_reg) & ~error_reg) == '0))
    else $error("error bit dropped without a return to normal");

  chk_error_clear: assert property (error_clear && !fault_pop |=> error_reg == '0)
    else $error("error register not cleared on return to normal");

endmodule

/* verif/controller_model.sv */
`timescale 1ns/1ps
// ==========================================
// system controller that drives the pins
module controller_model
(
  input wire logic sys_clk, // system clock
  output logic shift_clk, // shift clock pin
  output logic serial_in, // serial data pin
  output logic latch_strobe_ctl_one, // strobe pin
  output logic output_blank_ctl_two // blank pin
);
  // idle levels follow the pulls: strobe low, blank high
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe_ctl_one = 1'b0;
    output_blank_ctl_two = 1'b1;
  end

  // one shift edge; pins held well past the sync delay around the rise
  task automatic clock_bit(input logic d, input logic le, input logic oe);
  begin
    @(posedge sys_clk);
    serial_in <= d;
    latch_strobe_ctl_one <= le;
    output_blank_ctl_two <= oe;
    shift_clk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    shift_clk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    serial_in <= ~d; // data has no pull, so hold time over shows a new level
    repeat (3) @(posedge sys_clk);
  end
  endtask

  // strobe and blank levels with the shift clock standing still
  task automatic set_pins(input logic le, input logic oe);
  begin
    @(posedge sys_clk);
    latch_strobe_ctl_one <= le;
    output_blank_ctl_two <= oe;
    repeat (8) @(posedge sys_clk);
  end
  endtask
endmodule

/* verif/led_sink_serial_control_tb_top.sv */
`timescale 1ns/1ps
`define CHECK(act, exp) \
  begin \
    n_compared++; \
    if ((act) !== (exp)) \
    begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, act, exp); \
    end \
  end
// ==========================================
// bench top
module led_sink_serial_control_tb_top;
  logic sys_clk, reset, shift_clk, serial_in, strobe, blank;
  logic fault_valid, fault_ready, serial_out, special_mode, in_special;
  logic [15:0] fault_word, sink_channels, adjust_code, sr, exp_latch;
  int num_errors, n_compared, cycles, n;

  controller_model ctl_u
  (
    .sys_clk(sys_clk),
    .shift_clk(shift_clk),
    .serial_in(serial_in),
    .latch_strobe_ctl_one(strobe),
    .output_blank_ctl_two(blank)
  );

  led_sink_serial_control dut_u
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .shift_clk(shift_clk),
    .serial_in(serial_in),
    .latch_strobe_ctl_one(strobe),
    .output_blank_ctl_two(blank),
    .fault_valid(fault_valid),
    .fault_word(fault_word),
    .fault_ready(fault_ready),
    .serial_out(serial_out),
    .sink_channels(sink_channels),
    .current_adjust_code(adjust_code),
    .special_mode(special_mode)
  );

  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // a hang is cut short well past the expected run of about 1500 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
  begin
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // one bit, with a model of the shift register and normal-mode latch
  task automatic send_bit(input logic d, input logic le, input logic oe);
  begin
    ctl_u.clock_bit(d, le, oe);
    sr = {sr[14:0], d};
    if (le && !in_special)
      exp_latch = sr;
  end
  endtask

  task automatic send_word(input logic [15:0] w, input logic oe);
  begin
    for (int i = 15; i >= 0; i--)
      send_bit(w[i], 1'b0, oe);
  end
  endtask

  // serial_out shows bit 15 first, then one bit per shift edge
  task automatic read_word(input logic [15:0] w);
  begin
    for (int i = 15; i >= 0; i--)
    begin
      `CHECK(serial_out, w[i])
      send_bit(1'b0, 1'b0, 1'b1);
    end
  end
  endtask

  task automatic test_shift();
  begin
    send_word(16'hA5C3, 1'b1);
    read_word(16'hA5C3);
    $display("test shift done");
  end
  endtask

  task automatic test_latch();
  begin
    send_word(16'h3C5A, 1'b1);
    ctl_u.set_pins(1'b1, 1'b1);
    ctl_u.set_pins(1'b0, 1'b1);
    `CHECK(sink_channels, 16'h0000)
    send_word(16'h0F0F, 1'b1);
    ctl_u.set_pins(1'b0, 1'b0);
    `CHECK(sink_channels, 16'h3C5A)
    ctl_u.set_pins(1'b0, 1'b1);
    exp_latch = 16'h3C5A;
    $display("test latch done");
  end
  endtask

  // one-edge blank pulse with strobe high enters special mode
  task automatic test_special();
  begin
    send_bit(1'b0, 1'b0, 1'b1);
    send_bit(1'b1, 1'b1, 1'b0);
    send_bit(1'b0, 1'b0, 1'b1);
    in_special = 1'b1;
    `CHECK(special_mode, 1'b1)
    send_word(16'h00B7, 1'b1);
    ctl_u.set_pins(1'b1, 1'b1);
    ctl_u.set_pins(1'b0, 1'b1);
    `CHECK(adjust_code, 16'h00B7)
    ctl_u.set_pins(1'b0, 1'b0);
    `CHECK(sink_channels, exp_latch)
    $display("test special done");
  end
  endtask

  // fill the fault buffer while blanked, drain it, read the status out
  task automatic test_errors();
  begin
    ctl_u.set_pins(1'b0, 1'b1);
    n = 0;
    fault_word <= 16'h8001;
    fault_valid <= 1'b1;
    repeat (24)
    begin
      @(posedge sys_clk);
      if (fault_valid && fault_ready)
      begin
        n++;
        fault_word <= n[0] ? 16'h0240 : 16'h8001;
      end
    end
    fault_valid <= 1'b0;
    `CHECK(n, led_sink_pkg::FIFO_DEPTH)
    `CHECK(fault_ready, 1'b0)
    ctl_u.set_pins(1'b0, 1'b0);
    repeat (30) @(posedge sys_clk);
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b0, 1'b1);
    read_word(16'h8241);
    $display("test errors done");
  end
  endtask

  // back to normal clears the errors; a second read shows none
  task automatic test_return();
  begin
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b0, 1'b1);
    in_special = 1'b0;
    `CHECK(special_mode, 1'b0)
    send_bit(1'b0, 1'b1, 1'b0);
    `CHECK(sink_channels, exp_latch)
    send_bit(1'b0, 1'b0, 1'b1);
    in_special = 1'b1;
    `CHECK(special_mode, 1'b1)
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b0, 1'b1);
    read_word(16'h0000);
    $display("test return done");
  end
  endtask

  initial
  begin
    reset = 1'b1;
    fault_valid = 1'b0;
    fault_word = 16'h0000;
    sr = 16'h0000;
    exp_latch = 16'h0000;
    in_special = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    test_shift();
    test_latch();
    test_special();
    test_errors();
    test_return();
    results();
  end
endmodule
